// *** kwd_params.svh ***
/*
 * Constants of the keyed watchdog: register offset, command codes,
 * field positions, reset values and synchronisation counts.
 * Assumes inclusion by bare name from the package and the design.
 */
`ifndef KWD_PARAMS_SVH
`define KWD_PARAMS_SVH

`define KWD_ADDR_CTRL 8'h97
`define KWD_CMD_RELOAD 8'ha5
`define KWD_CMD_DIS1 8'hde
`define KWD_CMD_DIS2 8'had
`define KWD_CMD_LOCK 8'hff
`define KWD_CMD_BIT 7
`define KWD_SEL_MSB 2
`define KWD_ACT_BIT 4
`define KWD_SEL_RST 3'h7
`define KWD_ARM_WIN 3'h4
`define KWD_EN_TICKS 2'h2
`define KWD_DIS_TICKS 2'h3
`define KWD_EXP_BASE 5'h06
`define KWD_DIV_LOG2 5'h04
`define KWD_CNT_W 16

`endif

// *** kwd_pkg.sv ***
/*
 * Types of the keyed watchdog: bus request carrier and module state.
 * Assumes kwd_params.svh is on the include path.
 */
`include "kwd_params.svh"

package kwd_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } kwd_bus_req_type;

    typedef struct packed {
        logic enabled;
        logic lock;
        logic [`KWD_SEL_MSB:0] sel;
        logic [`KWD_CNT_W-1:0] cnt;
        logic [2:0] arm_cnt;
        logic en_pend;
        logic [1:0] en_ticks;
        logic dis_pend;
        logic [1:0] dis_ticks;
        logic rst_req;
        logic lfo_force;
        logic [7:0] rdata;
    } kwd_state_type;

endpackage : kwd_pkg

// *** kwd_watchdog.sv ***
/*
 * Keyed watchdog timer: one command/control register, a 16-bit counter
 * advanced by divided low-frequency oscillator ticks, reset request out.
 * Assumes lfo_tick_in is a one-cycle pulse per divided oscillator
 * period (oscillator divided by 16), synchronous to clk_in, and that the
 * system returns rst_n_in low after a reset request.
 */
// The address-and-strobe port is this design's own decision.
//
// Contract
// - counter reaching programmed limit forces a whole system reset
// - after reset: enabled, running, interval select reads all ones
// - writing 0xa5 enables the watchdog and clears the counter
// - while enabled the 16-bit counter advances on each divided tick
// - 0xde then 0xad within four clocks disables; else ignored
// - disabling holds the counter value, it is not cleared
// - limit comparison always active, can reset even when disabled
// - 0xff locks out disabling until reset; no enable, no clear
// - write with bit 7 clear loads interval select from bits 2..0
// - read returns interval in bits 2..0 and active flag in bit 4
// - eight selections span nominally 0.8 ms to 13.1 s
// - delays: enable two ticks, interval one clock, disable three ticks
// - oscillator forced on whenever the watchdog is active
// - watchdog reset leaves the external reset pin untouched
`timescale 1ns/1ps

`include "kwd_params.svh"

module kwd_watchdog (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire kwd_pkg::kwd_bus_req_type bus_in,
    input wire logic lfo_tick_in,
    output logic [7:0] rdata_out,
    output logic wdt_rst_req_out,
    output logic active_out,
    output logic lfo_force_on_out
);
    import kwd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state

    kwd_state_type st_r;
    kwd_state_type st_nxt;

    ////////////////////////////////////////////////////////////////////////
    // decode of the one register

    logic hit_ctrl;
    logic wr_ctrl;
    logic rd_ctrl;
    logic [7:0] wval;

    assign hit_ctrl = (bus_in.addr == `KWD_ADDR_CTRL);
    assign wr_ctrl = bus_in.wr && hit_ctrl;
    assign rd_ctrl = bus_in.rd && hit_ctrl;
    assign wval = bus_in.wdata;

    logic cmd_reload;
    logic cmd_dis1;
    logic cmd_dis2;
    logic cmd_lock;
    logic cmd_sel;

    assign cmd_reload = wr_ctrl && (wval == `KWD_CMD_RELOAD);
    assign cmd_dis1 = wr_ctrl && (wval == `KWD_CMD_DIS1);
    assign cmd_dis2 = wr_ctrl && (wval == `KWD_CMD_DIS2);
    assign cmd_lock = wr_ctrl && (wval == `KWD_CMD_LOCK);
    assign cmd_sel = wr_ctrl && !wval[`KWD_CMD_BIT];

    ////////////////////////////////////////////////////////////////////////
    // timeout limit in divided ticks
    // four to the (3 + sel) oscillator periods, divided by the prescale of
    // sixteen: 2^(6 + 2*sel - 4). the top setting needs 65536 ticks, so
    // the compare is done against limit - 1 to stay inside 16 bits.

    localparam int NSEL = 1 << (`KWD_SEL_MSB + 1);

    logic [`KWD_CNT_W-1:0] lim_tab [NSEL];
    logic [`KWD_CNT_W-1:0] lim_m1;

    // one constant entry per interval selection, picked by the select
    for (genvar gi = 0; gi < NSEL; gi++) begin : g_lim
        localparam int SHIFT = 2 * gi + `KWD_EXP_BASE - `KWD_DIV_LOG2;
        localparam logic [`KWD_CNT_W:0] FULL =
            (17'h00001 << SHIFT) - 17'h00001;
        assign lim_tab[gi] = FULL[`KWD_CNT_W-1:0];
    end

    assign lim_m1 = lim_tab[st_r.sel];

    logic expire;

    // compare runs whether enabled or not; a lowered interval can already
    // lie below the held count and fires at once
    assign expire = (st_r.cnt > lim_m1)
        || (st_r.cnt == lim_m1 && st_r.enabled && lfo_tick_in);

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_nxt = st_r;

        // disable key window: counts down after the first key
        if (st_r.arm_cnt != 3'h0) begin
            st_nxt.arm_cnt = st_r.arm_cnt - 3'h1;
        end
        if (wr_ctrl) begin
            st_nxt.arm_cnt = 3'h0;
        end
        if (cmd_dis1) begin
            st_nxt.arm_cnt = `KWD_ARM_WIN;
        end

        // second key only counts inside the window and without lockout
        if (cmd_dis2 && st_r.arm_cnt != 3'h0 && !st_r.lock) begin
            st_nxt.dis_pend = 1'b1;
            st_nxt.dis_ticks = 2'h0;
            st_nxt.en_pend = 1'b0;
        end

        if (cmd_reload) begin
            st_nxt.en_pend = 1'b1;
            st_nxt.en_ticks = 2'h0;
            st_nxt.dis_pend = 1'b0;
        end

        // lockout only; enable and count are left alone
        if (cmd_lock) begin
            st_nxt.lock = 1'b1;
        end

        // interval takes effect one system clock after the write
        if (cmd_sel) begin
            st_nxt.sel = wval[`KWD_SEL_MSB:0];
        end

        // counting on the divided tick
        if (lfo_tick_in && st_r.enabled) begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
        end

        // commands cross into the tick domain with fixed tick delays
        if (lfo_tick_in && st_r.en_pend && !cmd_reload) begin
            st_nxt.en_ticks = st_r.en_ticks + 2'h1;
            if (st_r.en_ticks + 2'h1 == `KWD_EN_TICKS) begin
                st_nxt.en_pend = 1'b0;
                st_nxt.enabled = 1'b1;
                st_nxt.cnt = 16'h0000;
            end
        end
        if (lfo_tick_in && st_r.dis_pend && !cmd_dis2) begin
            st_nxt.dis_ticks = st_r.dis_ticks + 2'h1;
            if (st_r.dis_ticks + 2'h1 == `KWD_DIS_TICKS) begin
                st_nxt.dis_pend = 1'b0;
                st_nxt.enabled = 1'b0;
                st_nxt.cnt = st_r.cnt;
            end
        end

        // request stays until the system reset comes back around
        if (expire) begin
            st_nxt.rst_req = 1'b1;
        end

        // oscillator held on while active or an enable is on its way
        st_nxt.lfo_force = st_nxt.enabled || st_nxt.en_pend;

        // read data stand in the cycle after the strobe only
        st_nxt.rdata = 8'h00;
        if (rd_ctrl) begin
            st_nxt.rdata[`KWD_SEL_MSB:0] = st_r.sel;
            st_nxt.rdata[`KWD_ACT_BIT] = st_r.enabled;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
            st_r.enabled <= 1'b1;
            st_r.sel <= `KWD_SEL_RST;
            st_r.lfo_force <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    // the request feeds the internal reset tree only; the external reset
    // pin has no driver here

    assign rdata_out = st_r.rdata;
    assign wdt_rst_req_out = st_r.rst_req;
    assign active_out = st_r.enabled;
    assign lfo_force_on_out = st_r.lfo_force;

endmodule : kwd_watchdog

// *** kwd_watchdog_assertions.sv ***
/* port checker for kwd_watchdog
   assumes one clock and a bind onto every instance */
`timescale 1ns/1ps
module kwd_watchdog_chk (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire kwd_pkg::kwd_bus_req_type bus_in,
    input wire logic lfo_tick_in,
    input wire logic [7:0] rdata_out,
    input wire logic wdt_rst_req_out,
    input wire logic active_out,
    input wire logic lfo_force_on_out
);
    import kwd_pkg::*;
    logic hit;
    assign hit = bus_in.addr == 8'h97;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////
    a_req_sticky: assert property (wdt_rst_req_out |=> wdt_rst_req_out)
        else $error("reset request dropped");
    a_reset_vals: assert property ($rose(rst_n_in) |-> active_out
        && lfo_force_on_out && !wdt_rst_req_out) else $error("bad reset");
    a_read_idle: assert property (!(bus_in.rd && hit) |=>
        rdata_out == 8'h00) else $error("read data outside read");
    a_read_zero: assert property (bus_in.rd && hit |=>
        rdata_out[7:5] == 3'h0 && !rdata_out[3]) else $error("bad read bits");
    a_force_active: assert property (active_out |-> lfo_force_on_out)
        else $error("oscillator not forced");
    a_force_pend: assert property (bus_in.wr && hit &&
        bus_in.wdata == 8'ha5 |-> ##[1:2] lfo_force_on_out) else $error("no force");
    a_act_tick: assert property (!lfo_tick_in |=> $stable(active_out))
        else $error("active changed without tick");
    a_sel_load: assert property (bus_in.wr && hit && !bus_in.wdata[7]
        ##1 !bus_in.wr ##1 bus_in.rd && hit |=>
        rdata_out[2:0] == $past(bus_in.wdata[2:0], 3)) else $error("bad sel");
    c_req: cover property ($rose(wdt_rst_req_out));
    c_off: cover property ($fell(active_out));
    c_on: cover property ($rose(active_out));
endmodule : kwd_watchdog_chk
bind kwd_watchdog kwd_watchdog_chk u_chk (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .bus_in(bus_in), .lfo_tick_in(lfo_tick_in),
    .rdata_out(rdata_out), .wdt_rst_req_out(wdt_rst_req_out),
    .active_out(active_out), .lfo_force_on_out(lfo_force_on_out));

// *** kwd_watchdog_tb.sv ***
/* self-checking bench for kwd_watchdog
   assumes the checker binds itself from its own file */
`timescale 1ns/1ps
module kwd_watchdog_tb;
    import kwd_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    kwd_bus_req_type b = '0;
    logic tick = 1'b0;
    logic [7:0] rdata;
    logic req, act, force_on;
    int num_errors = 0;
    int compares = 0;
    // write data beside expected read; bit 7 set but no command is ignored
    logic [15:0] rows [4] = '{16'h0515, 16'h7b13, 16'h8513, 16'h0717};
    always #2.5 clk_in = ~clk_in;
    kwd_watchdog dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_in(b),
        .lfo_tick_in(tick), .rdata_out(rdata), .wdt_rst_req_out(req),
        .active_out(act), .lfo_force_on_out(force_on));
    ////////////////////////////////////////
    task chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task end_of_test;
        if (num_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test
    task do_reset;
        @(posedge clk_in) rst_n_in <= 1'b0;
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
    endtask : do_reset
    task wr(input logic [7:0] d);
        @(posedge clk_in) b <= '{1'b1, 1'b0, 8'h97, d};
        @(posedge clk_in) b <= '0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in) b <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_in) b <= '0;
        #1 chk(rdata, exp, "rdata");
    endtask : rd
    // spaced pulses keep commands one per tick period
    task ticks(input int n);
        repeat (n) begin
            @(posedge clk_in) tick <= 1'b1;
            @(posedge clk_in) tick <= 1'b0;
            repeat (2) @(posedge clk_in);
        end
    endtask : ticks
    ////////////////////////////////////////
    initial begin
        do_reset;
        rd(8'h97, 8'h17);
        chk(req, 1'b0, "req");
        chk(force_on, 1'b1, "force");
        rd(8'h98, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i][15:8]);
            rd(8'h97, rows[i][7:0]);
        end
        wr(8'hde);
        wr(8'had);
        ticks(2);
        #1 chk(act, 1'b1, "active");
        ticks(1);
        #1 chk(act, 1'b0, "active");
        chk(force_on, 1'b0, "force");
        rd(8'h97, 8'h07);
        wr(8'ha5);
        ticks(1);
        #1 chk(act, 1'b0, "active");
        chk(force_on, 1'b1, "force");
        ticks(1);
        #1 chk(act, 1'b1, "active");
        wr(8'hde);
        repeat (5) @(posedge clk_in);
        wr(8'had);
        ticks(3);
        #1 chk(act, 1'b1, "active");
        wr(8'hff);
        ticks(1);
        wr(8'hde);
        wr(8'had);
        ticks(3);
        #1 chk(act, 1'b1, "active");
        do_reset;
        wr(8'h00);
        wr(8'ha5);
        ticks(5);
        #1 chk(req, 1'b0, "req");
        ticks(1);
        #1 chk(req, 1'b1, "req");
        // safe lowering: reload, wait, disable, wait, then new interval
        do_reset;
        wr(8'h01);
        ticks(10);
        wr(8'ha5);
        ticks(2);
        wr(8'hde);
        wr(8'had);
        ticks(3);
        wr(8'h00);
        repeat (2) @(posedge clk_in);
        #1 chk(req, 1'b0, "req");
        do_reset;
        wr(8'h01);
        ticks(10);
        wr(8'hde);
        wr(8'had);
        ticks(3);
        #1 chk(act, 1'b0, "active");
        chk(req, 1'b0, "req");
        // lowered limit below the held count, no tick needed
        wr(8'h00);
        repeat (2) @(posedge clk_in);
        #1 chk(req, 1'b1, "req");
        end_of_test;
    end
endmodule : kwd_watchdog_tb
